// file: inc/bitrev_pkg.sv
/*
 * constants, types and register map of the bit-reversed address generator.
 * assumes one core clock and an execution unit on that clock that sends
 * one request per cycle to each of the write and read address generators.
 */
// Contract
// RQ1: bit-reversed addressing is on only when the pointer select is not 15, the reverse enable is set and the mode is pre- or post-increment indirect.
// RQ2: software places a 2^N byte bit-reversed buffer at a start address whose low N bits are zero.
// RQ3: the reverse control register holds a 15-bit reverse modifier in bits 14:0, usually half the buffer size.
// RQ4: bit-reversed addresses assume word data, so the modifier is scaled to bytes and address bit 0 is forced to zero.
// RQ5: other indirect modes and byte writes get normal addresses even while the mode is enabled.
// RQ6: while active, the modifier is added to the pointer and the normal increment is ignored.
// RQ7: with modulo and bit-reversed both on, bit-reversed wins in the write address generator and modulo is off there.
// RQ8: modulo correction keeps working in the read address generator.
// RQ9: software does not follow a reverse control write at once with an indirect read through the bit-reversed pointer.
// RQ10: software should not enable modulo and bit-reversed addressing together.
// RQ11: the modifier is treated as bit-order reversed while source and destination stay in normal order.
// RQ12: bit-reversed generation exists only in the write address generator, for data writes.
// RQ13: the modifier add is a reverse-carry add, carries running from the msb toward the lsb.
package bitrev_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [2:0] MODCTL_OFS = 3'h0;
    localparam logic [2:0] REVCTL_OFS = 3'h1;
    localparam logic [2:0] MODSTART_OFS = 3'h2;
    localparam logic [2:0] MODEND_OFS = 3'h3;
    localparam logic [2:0] LASTEA_OFS = 3'h4;

    localparam int MOD_EN_BIT = 15;
    localparam int REV_EN_BIT = 15;
    localparam int REV_SEL_LSB = 8;
    localparam int MOD_SEL_LSB = 0;
    localparam int MODIFIER_MSB = 14;

    localparam logic [15:0] MODCTL_RST = 16'h0F0F;
    localparam logic [15:0] REVCTL_RST = 16'h0000;
    localparam logic [15:0] MODSTART_RST = 16'h0000;
    localparam logic [15:0] MODEND_RST = 16'hFFFF;
    localparam logic [3:0] STACK_SEL = 4'hF;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] BYTE_STEP = 16'h0001;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_IND,
        MODE_POST_DEC,
        MODE_POST_INC,
        MODE_PRE_DEC,
        MODE_PRE_INC
    } mode_t;

    typedef struct packed {
        logic valid;
        logic [3:0] ptr_sel;
        logic [15:0] ptr;
        mode_t mode;
        logic byte_size;
    } addr_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] eff_addr;
        logic wb_en;
        logic [15:0] wb_value;
    } addr_res_t;

endpackage : bitrev_pkg

// file: design/reverse_carry_adder.sv
/*
 * reverse-carry adder for bit-reversed pointer updates.
 * assumes word data: bit 0 of the pointer is dropped, the modifier is
 * already scaled to bytes by the caller.
 */
module reverse_carry_adder (
    // operands
    input wire logic [15:0] ptr_i,
    input wire logic [15:0] modifier_i,
    // result
    output logic [15:0] sum_o
);

    logic [14:0] ptr_rev;
    logic [14:0] mod_rev;
    logic [14:0] sum_rev;

    // ------------------------------------------------------------
    // mirror, add, mirror back
    // ------------------------------------------------------------
    // mirroring lets a plain adder carry from msb toward lsb
    for (genvar i = 0; i < 15; i++) begin : g_mirror
        assign ptr_rev[i] = ptr_i[15 - i]; // RQ11
        assign mod_rev[i] = modifier_i[15 - i];
        assign sum_o[15 - i] = sum_rev[i];
    end

    assign sum_rev = ptr_rev + mod_rev; // RQ13
    assign sum_o[0] = 1'b0; // RQ4

endmodule : reverse_carry_adder

// file: design/bit_reversed_address_gen.sv
/*
 * write address generator with bit-reversed and modulo addressing, read address
 * generator with modulo only, plus their control registers on a plain register port.
 * assumes requests come from execution logic on mclk_i; no synchronisers.
 */
module bit_reversed_address_gen (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // write address generator
    input wire bitrev_pkg::addr_req_t wr_req_i,
    output bitrev_pkg::addr_res_t wr_res_o,
    output logic brev_active_o,
    // read address generator
    input wire bitrev_pkg::addr_req_t rd_req_i,
    output bitrev_pkg::addr_res_t rd_res_o
);

    logic [15:0] modulo_control_reg_r;
    logic [15:0] reverse_control_reg_r;
    logic [15:0] mod_start_r;
    logic [15:0] mod_end_r;
    logic [15:0] last_addr_r;
    logic [15:0] rc_sum;
    logic brev;
    bitrev_pkg::addr_res_t wr_nxt;
    bitrev_pkg::addr_res_t rd_nxt;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // modulo applies only to the pointer picked in the modulo select field
    function automatic logic modulo_hit(input bitrev_pkg::addr_req_t req, input logic [15:0] modctl);
        modulo_hit = modctl[bitrev_pkg::MOD_EN_BIT] && (req.ptr_sel == modctl[bitrev_pkg::MOD_SEL_LSB +: 4]);
    endfunction : modulo_hit

    // normal indirect step with optional modulo wrap of the moved pointer
    function automatic bitrev_pkg::addr_res_t normal_step(input bitrev_pkg::addr_req_t req, input logic mod_on,
                                                         input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] step;
        logic [15:0] len;
        logic [15:0] moved;
        bitrev_pkg::addr_res_t res;
        step = req.byte_size ? bitrev_pkg::BYTE_STEP : bitrev_pkg::WORD_STEP;
        len = hi - lo + bitrev_pkg::BYTE_STEP;
        moved = req.ptr;
        res.valid = req.valid;
        res.wb_en = 1'b1;
        if (req.mode == bitrev_pkg::MODE_PRE_INC || req.mode == bitrev_pkg::MODE_POST_INC) begin
            moved = req.ptr + step;
            if (mod_on && moved > hi) begin
                moved = moved - len;
            end
        end else if (req.mode == bitrev_pkg::MODE_PRE_DEC || req.mode == bitrev_pkg::MODE_POST_DEC) begin
            moved = req.ptr - step;
            if (mod_on && moved < lo) begin
                moved = moved + len;
            end
        end else begin
            res.wb_en = 1'b0;
        end
        res.wb_value = moved;
        res.eff_addr = (req.mode == bitrev_pkg::MODE_PRE_INC || req.mode == bitrev_pkg::MODE_PRE_DEC) ? moved : req.ptr;
        return res;
    endfunction : normal_step

    // ------------------------------------------------------------
    // bit-reversed path
    // ------------------------------------------------------------
    reverse_carry_adder u_rc_add (
        .ptr_i(wr_req_i.ptr),
        .modifier_i({reverse_control_reg_r[bitrev_pkg::MODIFIER_MSB:0], 1'b0}), // RQ4
        .sum_o(rc_sum)
    );

    // enable needs a non-stack pointer, the enable bit, an increment mode and word data
    assign brev = wr_req_i.valid
               && modulo_control_reg_r[bitrev_pkg::REV_SEL_LSB +: 4] != bitrev_pkg::STACK_SEL // RQ1
               && wr_req_i.ptr_sel == modulo_control_reg_r[bitrev_pkg::REV_SEL_LSB +: 4]
               && reverse_control_reg_r[bitrev_pkg::REV_EN_BIT] // RQ1
               && (wr_req_i.mode == bitrev_pkg::MODE_PRE_INC || wr_req_i.mode == bitrev_pkg::MODE_POST_INC) // RQ1
               && !wr_req_i.byte_size; // RQ5

    // write side: bit-reversed result overrides the normal and modulo path
    always_comb begin
        wr_nxt = normal_step(wr_req_i, modulo_hit(wr_req_i, modulo_control_reg_r), mod_start_r, mod_end_r);
        if (brev) begin // RQ7
            wr_nxt.wb_en = 1'b1;
            wr_nxt.wb_value = rc_sum; // RQ6
            wr_nxt.eff_addr = (wr_req_i.mode == bitrev_pkg::MODE_PRE_INC) ? rc_sum : {wr_req_i.ptr[15:1], 1'b0}; // RQ4
        end
    end

    // read side never reverses, but modulo still wraps here
    always_comb begin
        rd_nxt = normal_step(rd_req_i, modulo_hit(rd_req_i, modulo_control_reg_r), mod_start_r, mod_end_r); // RQ8 RQ12
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // results leave one cycle after the request, straight from flops
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_res_o <= '0;
            rd_res_o <= '0;
            brev_active_o <= 1'b0;
        end else begin
            wr_res_o <= wr_nxt;
            rd_res_o <= rd_nxt;
            brev_active_o <= brev;
        end
    end

    // last write address kept for software to inspect
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_addr_r <= '0;
        end else if (wr_nxt.valid) begin
            last_addr_r <= wr_nxt.eff_addr;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // new control takes effect on the next request; no bypass, so the
    // request in the same cycle as a write still sees the old setting
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            modulo_control_reg_r <= bitrev_pkg::MODCTL_RST;
            reverse_control_reg_r <= bitrev_pkg::REVCTL_RST;
            mod_start_r <= bitrev_pkg::MODSTART_RST;
            mod_end_r <= bitrev_pkg::MODEND_RST;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                bitrev_pkg::MODCTL_OFS: modulo_control_reg_r <= reg_wdata_i;
                bitrev_pkg::REVCTL_OFS: reverse_control_reg_r <= reg_wdata_i; // RQ3 RQ9
                bitrev_pkg::MODSTART_OFS: mod_start_r <= reg_wdata_i;
                bitrev_pkg::MODEND_OFS: mod_end_r <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                bitrev_pkg::MODCTL_OFS: reg_rdata_o <= modulo_control_reg_r;
                bitrev_pkg::REVCTL_OFS: reg_rdata_o <= reverse_control_reg_r;
                bitrev_pkg::MODSTART_OFS: reg_rdata_o <= mod_start_r;
                bitrev_pkg::MODEND_OFS: reg_rdata_o <= mod_end_r;
                bitrev_pkg::LASTEA_OFS: reg_rdata_o <= last_addr_r;
                default: reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_brev_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ1
        brev_active_o |-> $past(reverse_control_reg_r[15]) && $past(modulo_control_reg_r[11:8]) != 4'hF)
        else $error("bit-reversed active without its enable conditions");

    a_modifier_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ3
        reg_wr_i && reg_addr_i == bitrev_pkg::REVCTL_OFS |=> reverse_control_reg_r[14:0] == $past(reg_wdata_i[14:0]))
        else $error("reverse modifier not stored");

    a_word_lsb: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ4
        brev_active_o |-> !wr_res_o.eff_addr[0] && !wr_res_o.wb_value[0] && wr_res_o.wb_en)
        else $error("bit-reversed address has bit 0 set");

    a_byte_normal: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ5
        wr_req_i.valid && (wr_req_i.byte_size || wr_req_i.mode == bitrev_pkg::MODE_IND) |=> !brev_active_o)
        else $error("bit-reversed used for byte or non-increment access");

    a_post_addr: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ6
        brev && wr_req_i.mode == bitrev_pkg::MODE_POST_INC |=> wr_res_o.eff_addr == {$past(wr_req_i.ptr[15:1]), 1'b0})
        else $error("post-increment bit-reversed address wrong");

    a_brev_prio: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ7
        brev && modulo_control_reg_r[15] |=> wr_res_o.wb_value == $past(rc_sum))
        else $error("modulo not overridden by bit-reversed");

    a_read_modulo: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ8
        rd_req_i.valid && modulo_hit(rd_req_i, modulo_control_reg_r) && rd_req_i.mode == bitrev_pkg::MODE_POST_INC
        && mod_start_r <= rd_req_i.ptr && rd_req_i.ptr <= mod_end_r && mod_end_r < 16'hFFF0
        |=> rd_res_o.wb_value <= $past(mod_end_r) && rd_res_o.wb_value >= $past(mod_start_r))
        else $error("read modulo wrap missing");

    a_read_plain: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ12
        rd_req_i.valid && rd_req_i.mode == bitrev_pkg::MODE_PRE_INC && !rd_req_i.byte_size
        && !modulo_control_reg_r[15] |=> rd_res_o.eff_addr == $past(rd_req_i.ptr) + 16'h0002)
        else $error("read generator did not step normally");

    a_readback: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RQ3
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside the answer cycle");

endmodule : bit_reversed_address_gen

// file: test/exec_model.sv
/*
 * execution-side partner: issues one request per cycle to each address
 * generator, as the instruction pipeline would.
 * assumes the bench hands it a command each cycle on mclk_i.
 */
module exec_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // commands from the bench
    input wire bitrev_pkg::addr_req_t wr_cmd_i,
    input wire bitrev_pkg::addr_req_t rd_cmd_i,
    // requests to the generators
    output bitrev_pkg::addr_req_t wr_req_o,
    output bitrev_pkg::addr_req_t rd_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // issue stage, launched just after the edge; no request during reset
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_req_o <= '0;
            rd_req_o <= '0;
        end else begin
            wr_req_o <= wr_cmd_i;
            rd_req_o <= rd_cmd_i;
        end
    end
endmodule : exec_model

// file: test/bit_reversed_address_gen_bench.sv
/*
 * self-checking bench for the bit-reversed address generator.
 * assumes bitrev_pkg, the design and exec_model are compiled first.
 */
module bit_reversed_address_gen_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    logic mclk_i;
    logic reset_n_i;
    logic [2:0] reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [15:0] reg_rdata_o;
    logic brev_active_o;
    bitrev_pkg::addr_req_t wr_cmd, rd_cmd, wr_req_i, rd_req_i, q, m;
    bitrev_pkg::addr_res_t wr_res_o, rd_res_o;
    bitrev_pkg::addr_res_t qw[$], qr[$];
    logic qb[$];
    int n_mismatch, compares, seed;
    logic [31:0] r;
    logic [3:0] cfg_sel;
    logic cfg_en;
    logic [14:0] cfg_modifier;
    // 200 MHz core clock
    initial begin
        mclk_i = 1'h0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    bit_reversed_address_gen u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .wr_req_i(wr_req_i), .wr_res_o(wr_res_o), .brev_active_o(brev_active_o), .rd_req_i(rd_req_i),
        .rd_res_o(rd_res_o));
    exec_model u_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .wr_cmd_i(wr_cmd), .rd_cmd_i(rd_cmd),
        .wr_req_o(wr_req_i), .rd_req_o(rd_req_i));
    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    // reverse-carry add: add in mirrored bit order, word data so bit 0 is zero
    function automatic logic [15:0] rc(input logic [15:0] p, input logic [14:0] x);
        logic [14:0] a, b, s;
        logic [15:0] y;
        for (int i = 0; i < 15; i++) begin
            a[i] = p[15-i];
            b[i] = x[14-i];
        end
        s = a + b;
        y = '0;
        for (int i = 0; i < 15; i++) y[15-i] = s[i];
        return y;
    endfunction : rc
    // k-th word of an aligned 32-byte walk: the 4-bit word index mirrored into bits 4:1
    function automatic logic [15:0] walk_addr(input int k);
        return {11'h100, k[0], k[1], k[2], k[3], 1'h0};
    endfunction : walk_addr
    function automatic bitrev_pkg::addr_res_t normal(input bitrev_pkg::addr_req_t t);
        logic [15:0] s;
        s = t.byte_size ? bitrev_pkg::BYTE_STEP : bitrev_pkg::WORD_STEP;
        case (t.mode)
            bitrev_pkg::MODE_PRE_INC: return '{t.valid, t.ptr + s, 1'h1, t.ptr + s};
            bitrev_pkg::MODE_POST_INC: return '{t.valid, t.ptr, 1'h1, t.ptr + s};
            bitrev_pkg::MODE_PRE_DEC: return '{t.valid, t.ptr - s, 1'h1, t.ptr - s};
            bitrev_pkg::MODE_POST_DEC: return '{t.valid, t.ptr, 1'h1, t.ptr - s};
            default: return '{t.valid, t.ptr, 1'h0, t.ptr};
        endcase
    endfunction : normal
    function automatic logic active(input bitrev_pkg::addr_req_t t);
        return cfg_en && cfg_sel != bitrev_pkg::STACK_SEL && t.ptr_sel == cfg_sel && !t.byte_size &&
            (t.mode == bitrev_pkg::MODE_PRE_INC || t.mode == bitrev_pkg::MODE_POST_INC);
    endfunction : active
    function automatic bitrev_pkg::addr_res_t exp_w(input bitrev_pkg::addr_req_t t);
        logic [15:0] s;
        s = rc(t.ptr, cfg_modifier);
        if (!active(t)) return normal(t);
        return '{t.valid, (t.mode == bitrev_pkg::MODE_PRE_INC) ? s : {t.ptr[15:1], 1'h0}, 1'h1, s};
    endfunction : exp_w
    // random request; a quarter aim at the reverse pointer, a quarter at the stack
    function automatic bitrev_pkg::addr_req_t gen();
        bitrev_pkg::addr_req_t t;
        r = $random(seed);
        t.valid = 1'h1;
        t.ptr_sel = (r[1:0] == 2'h0) ? cfg_sel : (r[1:0] == 2'h1) ? bitrev_pkg::STACK_SEL : r[7:4];
        t.byte_size = r[2];
        t.ptr = r[31:16] & (r[2] ? 16'hFFFF : 16'hFFFE);
        t.mode = bitrev_pkg::mode_t'(3'(r[10:8] % 3'h5));
        return t;
    endfunction : gen
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic chk_res(input string nm, input bitrev_pkg::addr_res_t s, input bitrev_pkg::addr_res_t e);
        chk({nm, " valid"}, 16'(s.valid), 16'(e.valid));
        chk({nm, " eff_addr"}, s.eff_addr, e.eff_addr);
        chk({nm, " wb_en"}, 16'(s.wb_en), 16'(e.wb_en));
        if (e.wb_en) chk({nm, " wb_value"}, s.wb_value, e.wb_value);
    endtask : chk_res
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge mclk_i);
        reg_wr_i <= 1'h0;
    endtask : reg_wr
    task automatic reg_chk(input logic [2:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge mclk_i);
        reg_rd_i <= 1'h0;
        #1 chk("rdata", reg_rdata_o, e);
        @(posedge mclk_i);
        #1 chk("rdata idle", reg_rdata_o, 16'h0000);
    endtask : reg_chk
    // one request pair per cycle; a result lands two edges after its command
    task automatic step(input bitrev_pkg::addr_req_t w, input bitrev_pkg::addr_req_t v, input bitrev_pkg::addr_res_t er);
        @(posedge mclk_i);
        wr_cmd <= w;
        rd_cmd <= v;
        qw.push_back(exp_w(w));
        qb.push_back(active(w));
        qr.push_back(er);
        #1;
        if (qw.size() > 2) begin
            chk_res("wr", wr_res_o, qw.pop_front());
            chk("brev", 16'(brev_active_o), 16'(qb.pop_front()));
            chk_res("rd", rd_res_o, qr.pop_front());
        end
    endtask : step
    // drain the pipe with idle requests, leaving a gap before any control write
    task automatic flush();
        repeat (2) step('0, '0, '0);
        qw.delete();
        qb.delete();
        qr.delete();
    endtask : flush
    task automatic conclude();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge mclk_i);
        n_mismatch++;
        conclude();
    end
    initial begin
        seed = 32'hB211;
        {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
        wr_cmd = '0;
        rd_cmd = '0;
        reset_n_i = 1'h0;
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'h1;
        reg_chk(bitrev_pkg::MODCTL_OFS, bitrev_pkg::MODCTL_RST);
        reg_chk(bitrev_pkg::REVCTL_OFS, bitrev_pkg::REVCTL_RST);
        reg_chk(bitrev_pkg::MODEND_OFS, bitrev_pkg::MODEND_RST);
        reg_wr(3'h5, 16'hFFFF);
        reg_chk(3'h5, 16'h0000);
        $display("test registers done");
        // enabled, stack pointer selected, and disabled
        for (int c = 0; c < 3; c++) begin
            r = $random(seed);
            cfg_sel = (c == 1) ? bitrev_pkg::STACK_SEL : 4'h5;
            cfg_en = (c != 2);
            cfg_modifier = r[14:0];
            reg_wr(bitrev_pkg::MODCTL_OFS, {4'h0, cfg_sel, 8'h00});
            reg_wr(bitrev_pkg::REVCTL_OFS, {cfg_en, cfg_modifier});
            reg_chk(bitrev_pkg::REVCTL_OFS, {cfg_en, cfg_modifier});
            repeat (200) begin
                q = gen();
                step(q, q, normal(q));
            end
            flush();
            $display("test config %0d done", c);
        end
        // modulo and reverse both on for the same pointer
        cfg_sel = 4'h5;
        cfg_en = 1'h1;
        cfg_modifier = 15'h0001;
        reg_wr(bitrev_pkg::MODCTL_OFS, 16'h8505);
        reg_wr(bitrev_pkg::MODSTART_OFS, 16'h1000);
        reg_wr(bitrev_pkg::MODEND_OFS, 16'h101F);
        reg_wr(bitrev_pkg::REVCTL_OFS, 16'h8001);
        // pivot step gives 101C, a modulo wrap 1000 and a plain step 1020, so the winner shows
        q = '{1'h1, 4'h5, 16'h101E, bitrev_pkg::MODE_PRE_INC, 1'h0};
        m = q;
        m.mode = bitrev_pkg::MODE_POST_INC;
        step(q, m, '{1'h1, 16'h101E, 1'h1, 16'h1000});
        // a decrement below the start wraps up to the end of the read buffer
        m.ptr = 16'h1000;
        m.mode = bitrev_pkg::MODE_PRE_DEC;
        step('0, m, '{1'h1, 16'h101E, 1'h1, 16'h101E});
        flush();
        reg_chk(bitrev_pkg::LASTEA_OFS, 16'h101C);
        $display("test modulo priority done");
        // aligned 32-byte buffer, pivot of half the buffer in words, modulo off
        cfg_modifier = 15'h0008;
        reg_wr(bitrev_pkg::MODCTL_OFS, 16'h0500);
        reg_wr(bitrev_pkg::REVCTL_OFS, 16'h8008);
        for (int k = 0; k < 18; k++) begin
            q = '{1'h1, 4'h5, walk_addr(k), bitrev_pkg::MODE_POST_INC, 1'h0};
            step(q, '0, '0);
            if (k >= 2) chk("walk next", wr_res_o.wb_value, walk_addr(k - 1));
        end
        flush();
        $display("test buffer walk done");
        conclude();
    end
endmodule : bit_reversed_address_gen_bench
